// >>> scl_board_model.sv
// Board model: strap resistors and the shared pin wires
`timescale 1ns/1ps
module scl_board_model (
  input wire logic [4:0] addrStrap, // Resistor level per address pin
  input wire logic ifaceStrap, // Interface strap resistor level
  input wire logic fiberStrap, // Media strap resistor level
  input wire logic [4:0] addrOut, // Device drive values
  input wire logic [4:0] addrOe, // Device drive enables
  input wire logic ifaceOut, // Test signal drive value
  input wire logic ifaceOe, // Test signal drive enable
  input wire logic rxErrOut, // Receive-error drive value
  input wire logic rxErrOe, // Receive-error drive enable
  output logic [4:0] addrPin, // Wire level of address pins
  output logic ifacePin, // Wire level of interface pin
  output logic fiberPin // Wire level of receive-error pin
);
  // A released pin falls back to its resistor, so no wire ever floats
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      addrPin[i] = addrOe[i] ? addrOut[i] : addrStrap[i];
    end
    ifacePin = ifaceOe ? ifaceOut : ifaceStrap;
    fiberPin = rxErrOe ? rxErrOut : fiberStrap;
  end
endmodule

// >>> scl_pkg.sv
// Shared constants for the strap capture and indicator block
package scl_pkg;
  // Clock and timing
  localparam int CLK_HZ = 100_000_000;
  localparam int RESET_HOLD_MS = 10;
  localparam int RESET_HOLD_CYC = CLK_HZ / 1000 * RESET_HOLD_MS;
  localparam int BLINK_HALF_MS = 40;
  localparam int BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;
  localparam int CNT_W = 24;
  localparam int SYNC_W = 14;

  // Register byte offsets
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_CTRL = 4'h4;

  // Control register fields and reset values
  localparam int CTRL_TEST_BIT = 0;
  localparam int CTRL_LEDOFF_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // Status register field positions
  localparam int ST_ADDR_LSB = 0;
  localparam int ST_SPEED_BIT = 5;
  localparam int ST_DUPLEX_BIT = 6;
  localparam int ST_NEG_BIT = 7;
  localparam int ST_IFACE_BIT = 8;
  localparam int ST_FIBER_BIT = 9;
  localparam int ST_SHORT_BIT = 10;
  localparam int ST_RUN_BIT = 11;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Device phase
  typedef enum logic {PH_HOLD, PH_RUN} scl_phase_t;
endpackage

// >>> scl_strap_led.sv
// Strap capture, mode pins, status indicators and register slave
// Overview of operation
// - Latch speed strap at reset; high means 100M
// - Latch negotiation strap; high auto, low forced
// - Latch interface strap; high nibble, low serial
// - Test mode turns interface pin into output
// - Isolate high disconnects MAC, management; low power
// - Repeater select high gives repeater mode
// - Power-save pin is a live level
// - Latch five address pins as station address
// - After reset, address pins drive indicators
// - Latched high gives active-low indicator polarity
// - Bit-0 indicator shows link up
// - Bit-1 indicator shows full duplex
// - Bit-2 indicator: 10M link, blinks on activity
// - Bit-3 indicator: 100M copper link, blinks
// - Bit-4 indicator shows collision
// - Chip reset low resets all; hold 10 ms; here it restarts capture and clears control only, shorter holds are flagged
// - Receive-error pin latches fiber strap, then outputs
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module scl_strap_led #(
  parameter logic [23:0] RESET_HOLD_CYC = 24'(scl_pkg::RESET_HOLD_CYC),
  parameter logic [23:0] BLINK_HALF_CYC = 24'(scl_pkg::BLINK_HALF_CYC)
) (
  input wire logic sys_clk, // 100 MHz clock
  input wire logic sys_rst, // Synchronous power-on reset
  input wire logic chipResetN, // Chip reset pin, active low
  input wire logic isolatePin, // Isolation level pin
  input wire logic repeaterSelect, // Repeater mode level pin
  input wire logic linkDownPowerSavePin, // Power-save level pin
  input wire logic speedStrap, // Speed strap pin
  input wire logic duplexStrap, // Duplex strap pin
  input wire logic negotiationStrap, // Negotiation strap pin
  input wire logic interfaceTypeStrapIn, // Interface strap pin level
  output logic interfaceTypeStrapOut, // Test signal driven in test mode
  output logic interfaceTypeStrapOe, // Drive enable of interface pin
  input wire logic fiberMediaStrapIn, // Receive-error pin level
  output logic receiveErrorOut, // Receive-error pin drive value
  output logic receiveErrorOe, // Receive-error pin drive enable
  input wire logic [4:0] stationAddrIn, // Address pin levels
  output logic [4:0] stationAddrOut, // Indicator drive values
  output logic [4:0] stationAddrOe, // Indicator drive enables
  input wire logic linkUp, // Core: valid link
  input wire logic fullDuplex, // Core: full duplex in use
  input wire logic speed100, // Core: linked at 100M
  input wire logic frameActivity, // Core: frame sent or received
  input wire logic collision, // Core: collision seen
  input wire logic rxSymbolError, // Core: receive decode error
  output logic speedSel, // Latched speed, 1 = 100M
  output logic duplexSel, // Latched duplex, 1 = full
  output logic negEnable, // Latched negotiation enable
  output logic nibbleIface, // Latched interface, 1 = nibble
  output logic fiberMode, // Latched media, 1 = fiber
  output logic [4:0] stationAddr, // Latched station address
  output logic deviceRun, // Capture done, normal operation
  output logic macIsolate, // Disconnect MAC data path
  output logic mgmtIsolate, // Disconnect management interface
  output logic lowPower, // Lowest-power state request
  output logic repeaterMode, // Repeater mode active
  output logic powerSaveMode, // Link-down power saving active
  input wire logic [3:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [3:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready // Read data ready
);
  logic [scl_pkg::SYNC_W-1:0] pinsS;
  logic rstS, isoS, rptS, link_down_power_save_pin, spdS, dupS, negS, ifS, fibS;
  logic [4:0] addrS;
  logic inReset;
  scl_pkg::scl_phase_t phase_r;
  logic [23:0] lowCnt_r, blinkCnt_r;
  logic shortReset_r, blink_r, actSeen_r;
  logic [1:0] ctrl_r;
  logic [4:0] ledOn;
  logic awHeld_r, wHeld_r, doWrite;
  logic [3:0] awAddr_r;
  logic [31:0] wData_r, statusWord;
  logic [3:0] wStrb_r;

  // Every pin level crosses two flops before use
  scl_sync #(.W(scl_pkg::SYNC_W)) u_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .asyncIn({chipResetN, isolatePin, repeaterSelect,
      linkDownPowerSavePin, speedStrap, duplexStrap, negotiationStrap,
      interfaceTypeStrapIn, fiberMediaStrapIn, stationAddrIn}),
    .syncOut(pinsS)
  );
  assign {rstS, isoS, rptS, link_down_power_save_pin, spdS, dupS, negS, ifS, fibS, addrS} =
    pinsS;
  assign inReset = ~rstS;

  // Phase: hold while the chip reset pin is low, run after release
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      phase_r <= scl_pkg::PH_HOLD;
    end else if (inReset) begin
      phase_r <= scl_pkg::PH_HOLD;
    end else begin
      phase_r <= scl_pkg::PH_RUN;
    end
  end

  // Measure how long the reset pin stayed low; short pulses are flagged
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      lowCnt_r <= 24'h0;
      shortReset_r <= 1'b0;
    end else if (inReset) begin
      if (lowCnt_r < RESET_HOLD_CYC) begin
        lowCnt_r <= lowCnt_r + 24'h1;
      end
    end else begin
      if (phase_r == scl_pkg::PH_HOLD) begin
        shortReset_r <= (lowCnt_r < RESET_HOLD_CYC);
      end
      lowCnt_r <= 24'h0;
    end
  end

  // Straps follow the pins while held, and freeze at release
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      speedSel <= 1'b0;
      duplexSel <= 1'b0;
      negEnable <= 1'b0;
      nibbleIface <= 1'b0;
      fiberMode <= 1'b0;
      stationAddr <= 5'h0;
    end else if (phase_r == scl_pkg::PH_HOLD) begin
      speedSel <= spdS;
      duplexSel <= dupS;
      negEnable <= negS;
      nibbleIface <= ifS;
      fiberMode <= fibS;
      stationAddr <= addrS;
    end
  end

  // Capture updates the straps from the pins throughout the hold phase
  a_strap_capture: assert property (@(posedge sys_clk)
    disable iff (sys_rst) phase_r == scl_pkg::PH_HOLD |=>
      speedSel == $past(spdS)
      && duplexSel == $past(dupS) && negEnable == $past(negS)
      && nibbleIface == $past(ifS))
    else $error("strap not captured during hold");
  a_strap_freeze: assert property (@(posedge sys_clk)
    disable iff (sys_rst) deviceRun && phase_r == scl_pkg::PH_RUN |=>
      $stable(stationAddr) && $stable(fiberMode))
    else $error("strap changed while running");

  // Level pins act live; isolation also asks for lowest power
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      macIsolate <= 1'b0;
      mgmtIsolate <= 1'b0;
      lowPower <= 1'b0;
      repeaterMode <= 1'b0;
      powerSaveMode <= 1'b0;
      deviceRun <= 1'b0;
    end else begin
      macIsolate <= isoS;
      mgmtIsolate <= isoS;
      lowPower <= isoS;
      repeaterMode <= rptS;
      powerSaveMode <= link_down_power_save_pin;
      deviceRun <= (phase_r == scl_pkg::PH_RUN) && !inReset;
    end
  end

  a_isolate_follow: assert property (@(posedge sys_clk)
    disable iff (sys_rst) isoS |=> macIsolate && mgmtIsolate && lowPower)
    else $error("isolation not applied");
  a_mode_levels: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    ##1 repeaterMode == $past(rptS) && powerSaveMode == $past(link_down_power_save_pin))
    else $error("mode level not followed");

  // Blink divider: a fixed half period from the reference clock
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      blinkCnt_r <= 24'h0;
      blink_r <= 1'b0;
    end else if (blinkCnt_r >= BLINK_HALF_CYC - 24'h1) begin
      blinkCnt_r <= 24'h0;
      blink_r <= ~blink_r;
    end else begin
      blinkCnt_r <= blinkCnt_r + 24'h1;
    end
  end

  // Stretch activity pulses to one blink phase; a new pulse wins
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      actSeen_r <= 1'b0;
    end else if (frameActivity) begin
      actSeen_r <= 1'b1;
    end else if (blinkCnt_r == 24'h0 && !blink_r) begin
      actSeen_r <= 1'b0;
    end
  end

  // Indicator functions before polarity
  always_comb begin
    ledOn[0] = linkUp;
    ledOn[1] = fullDuplex;
    ledOn[2] = linkUp && !speed100 && !(actSeen_r && blink_r);
    ledOn[3] = linkUp && speed100 && !fiberMode
      && !(actSeen_r && blink_r);
    ledOn[4] = collision;
  end

  // Address pins turn to indicators once capture is over
  always_ff @(posedge sys_clk) begin
    if (sys_rst || phase_r == scl_pkg::PH_HOLD) begin
      stationAddrOe <= 5'h0;
      stationAddrOut <= 5'h0;
    end else begin
      stationAddrOe <= {5{~ctrl_r[scl_pkg::CTRL_LEDOFF_BIT]}};
      stationAddrOut <= ledOn ^ stationAddr;
    end
  end

  a_led_hold_off: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    phase_r == scl_pkg::PH_HOLD |=> stationAddrOe == 5'h0)
    else $error("indicator driven during capture");
  a_led_link: assert property (@(posedge sys_clk)
    disable iff (sys_rst) phase_r == scl_pkg::PH_RUN && linkUp |=>
      stationAddrOut[0] == ~stationAddr[0])
    else $error("link indicator wrong level");
  a_led_dup_coll: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    phase_r == scl_pkg::PH_RUN && !fullDuplex && collision |=>
      stationAddrOut[1] == stationAddr[1]
      && stationAddrOut[4] == ~stationAddr[4])
    else $error("duplex or collision indicator wrong");
  a_led_slow: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    phase_r == scl_pkg::PH_RUN && linkUp && !speed100 && !actSeen_r |=>
      stationAddrOut[2] == ~stationAddr[2]
      && stationAddrOut[3] == stationAddr[3])
    else $error("speed indicators wrong");

  // Receive-error pin: input strap while held, error output afterwards
  always_ff @(posedge sys_clk) begin
    if (sys_rst || phase_r == scl_pkg::PH_HOLD) begin
      receiveErrorOe <= 1'b0;
      receiveErrorOut <= 1'b0;
    end else begin
      receiveErrorOe <= 1'b1;
      receiveErrorOut <= rxSymbolError;
    end
  end

  // Interface pin becomes the test signal output only in test mode
  always_ff @(posedge sys_clk) begin
    if (sys_rst || phase_r == scl_pkg::PH_HOLD) begin
      interfaceTypeStrapOe <= 1'b0;
      interfaceTypeStrapOut <= 1'b0;
    end else begin
      interfaceTypeStrapOe <= ctrl_r[scl_pkg::CTRL_TEST_BIT];
      interfaceTypeStrapOut <= blink_r;
    end
  end

  a_test_pin: assert property (@(posedge sys_clk)
    disable iff (sys_rst) phase_r == scl_pkg::PH_RUN |=>
      interfaceTypeStrapOe == $past(ctrl_r[scl_pkg::CTRL_TEST_BIT])
      && receiveErrorOe)
    else $error("test or error pin enable wrong");

  // Write channel: address and data taken in either order
  assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      awAddr_r <= 4'h0;
      wData_r <= 32'h0;
      wStrb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld_r <= 1'b0;
      end
      s_axi_awready <= doWrite
        || !(awHeld_r || (s_axi_awvalid && s_axi_awready));
      s_axi_wready <= doWrite
        || !(wHeld_r || (s_axi_wvalid && s_axi_wready));
    end
  end

  // Control word; the chip reset pin clears it as well, so test mode and
  // indicator blanking never survive a reset. Writes while the chip reset pin is low are lost.
  always_ff @(posedge sys_clk) begin
    if (sys_rst || inReset) begin
      ctrl_r <= scl_pkg::CTRL_RESET;
    end else if (doWrite && wStrb_r[0]
        && awAddr_r[3:2] == scl_pkg::OFS_CTRL[3:2]) begin
      ctrl_r <= wData_r[1:0];
    end
  end

  // Write response; only the control word is writable
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= scl_pkg::RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      if (awAddr_r[3:2] == scl_pkg::OFS_CTRL[3:2]) begin
        s_axi_bresp <= scl_pkg::RESP_OKAY;
      end else if (awAddr_r[3:2] == scl_pkg::OFS_STATUS[3:2]) begin
        s_axi_bresp <= scl_pkg::RESP_OKAY; // Read-only, write ignored
      end else begin
        s_axi_bresp <= scl_pkg::RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Status word shows the captured straps and device phase
  always_comb begin
    statusWord = 32'h0;
    statusWord[scl_pkg::ST_ADDR_LSB +: 5] = stationAddr;
    statusWord[scl_pkg::ST_SPEED_BIT] = speedSel;
    statusWord[scl_pkg::ST_DUPLEX_BIT] = duplexSel;
    statusWord[scl_pkg::ST_NEG_BIT] = negEnable;
    statusWord[scl_pkg::ST_IFACE_BIT] = nibbleIface;
    statusWord[scl_pkg::ST_FIBER_BIT] = fiberMode;
    statusWord[scl_pkg::ST_SHORT_BIT] = shortReset_r;
    statusWord[scl_pkg::ST_RUN_BIT] = deviceRun;
  end

  // Read channel: one read at a time, data one cycle after address
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= scl_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= scl_pkg::RESP_OKAY;
      if (s_axi_araddr[3:2] == scl_pkg::OFS_STATUS[3:2]) begin
        s_axi_rdata <= statusWord;
      end else if (s_axi_araddr[3:2] == scl_pkg::OFS_CTRL[3:2]) begin
        s_axi_rdata <= {30'h0, ctrl_r};
      end else begin
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= scl_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end
endmodule

// >>> scl_sync.sv
// Two-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
module scl_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk, // System clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic [W-1:0] asyncIn, // Raw pin levels
  output logic [W-1:0] syncOut // Levels safe for logic
);
  logic [W-1:0] stage1_r;

  // First stage feeds only the second, to let metastability settle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      stage1_r <= '0;
      syncOut <= '0;
    end else begin
      stage1_r <= asyncIn;
      syncOut <= stage1_r;
    end
  end
endmodule

// >>> tb_top.sv
// Self-checking bench for strap capture, indicators and registers
`timescale 1ns/1ps
module tb_top;
  localparam int HALF = 8;
  logic sys_clk = 0, sys_rst = 1, chipResetN = 0;
  logic isolatePin = 0, repeaterSelect = 0, linkDownPowerSavePin = 0;
  logic speedStrap = 0, duplexStrap = 0, negotiationStrap = 0;
  logic ifaceStrap = 0, fiberStrap = 0;
  logic [4:0] addrStrap = 5'h00;
  logic linkUp = 0, fullDuplex = 0, speed100 = 0, frameActivity = 0;
  logic collision = 0, rxSymbolError = 0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic ifaceOut, ifaceOe, ifacePin, rxErrOut, rxErrOe, fiberPin;
  logic [4:0] addrOut, addrOe, addrPin, stationAddr;
  logic speedSel, duplexSel, negEnable, nibbleIface, fiberMode, deviceRun;
  logic macIsolate, mgmtIsolate, lowPower, repeaterMode, powerSaveMode;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, r;
  int num_errors = 0, check_count = 0, seed = 46792, n;
  logic [33:0] rdQ[$];
  logic [1:0] wrQ[$];

  // Short counts keep the run brief; expectations follow them
  scl_strap_led #(.RESET_HOLD_CYC(24'h000014), .BLINK_HALF_CYC(24'h000008))
  u_dut (.sys_clk, .sys_rst, .chipResetN, .isolatePin, .repeaterSelect,
    .linkDownPowerSavePin, .speedStrap, .duplexStrap, .negotiationStrap,
    .interfaceTypeStrapIn(ifacePin), .interfaceTypeStrapOut(ifaceOut),
    .interfaceTypeStrapOe(ifaceOe), .fiberMediaStrapIn(fiberPin),
    .receiveErrorOut(rxErrOut), .receiveErrorOe(rxErrOe),
    .stationAddrIn(addrPin), .stationAddrOut(addrOut),
    .stationAddrOe(addrOe), .linkUp, .fullDuplex, .speed100, .frameActivity,
    .collision, .rxSymbolError, .speedSel, .duplexSel, .negEnable,
    .nibbleIface, .fiberMode, .stationAddr, .deviceRun, .macIsolate,
    .mgmtIsolate, .lowPower, .repeaterMode, .powerSaveMode,
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  scl_board_model u_board (.addrStrap, .ifaceStrap, .fiberStrap, .addrOut,
    .addrOe, .ifaceOut, .ifaceOe, .rxErrOut, .rxErrOe, .addrPin, .ifacePin,
    .fiberPin);

  task automatic give_verdict();
    if (num_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic timedOut();
    num_errors++;
    give_verdict();
  endtask

  // Write: offer address and data together, release each once taken
  task automatic axiWrite(input logic [3:0] a, input logic [31:0] d,
                          input logic [1:0] er);
    int k;
    @(posedge sys_clk);
    wrQ.push_back(er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
      if (awready && awvalid) awvalid <= 0;
      if (wready && wvalid) wvalid <= 0;
    end while (bvalid !== 1'b1 && k < 100);
    bready <= 0;
    if (k >= 100) timedOut();
  endtask

  task automatic axiRead(input logic [3:0] a, input logic [33:0] e);
    int k;
    @(posedge sys_clk);
    rdQ.push_back(e);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
      if (arready && arvalid) arvalid <= 0;
    end while (rvalid !== 1'b1 && k < 100);
    rready <= 0;
    if (k >= 100) timedOut();
  endtask

  // Monitor: every bus answer is matched against the oldest note
  always @(posedge sys_clk) begin
    if (rvalid && rready) check({rresp, rdata}, rdQ.pop_front());
    if (bvalid && bready) check({32'h0, bresp},
                                {32'h0, wrQ.pop_front()});
  end

  // Hold the chip reset pin low, offer fresh straps, then release
  task automatic capture(input int holdCyc, input logic shortRst);
    r = $random(seed);
    chipResetN <= 0;
    {fiberStrap, ifaceStrap, negotiationStrap, duplexStrap, speedStrap,
     addrStrap} <= r[9:0];
    repeat (holdCyc) @(posedge sys_clk);
    check({33'h0, deviceRun}, 34'h0);
    check({29'h0, addrOe}, 34'h0);
    chipResetN <= 1;
    n = 0;
    while (deviceRun !== 1'b1 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 50) timedOut();
    repeat (2) @(posedge sys_clk);
    check({24'h0, fiberMode, nibbleIface, negEnable, duplexSel, speedSel,
           stationAddr}, {24'h0, r[9:0]});
    check({28'h0, rxErrOe, addrOe}, 34'h3f);
    axiRead(scl_pkg::OFS_STATUS, {scl_pkg::RESP_OKAY, 20'h0, 1'b1, shortRst,
            r[9:0]});
  endtask

  // Expected indicator levels: function flipped by the latched strap
  function automatic logic [4:0] ledExp();
    return {collision, linkUp & speed100 & !fiberStrap, linkUp & !speed100,
            fullDuplex, linkUp} ^ addrStrap;
  endfunction

  initial forever #5 sys_clk = ~sys_clk;

  initial begin
    repeat (100000) @(posedge sys_clk);
    timedOut();
  end

  initial begin
    repeat (5) @(posedge sys_clk);
    sys_rst <= 0;
    capture(30, 1'b0);
    axiRead(scl_pkg::OFS_CTRL, {scl_pkg::RESP_OKAY, 32'h0});
    // Random core status levels, no frame activity yet
    repeat (16) begin
      r = $random(seed);
      {linkUp, fullDuplex, speed100, collision, rxSymbolError} <= r[4:0];
      repeat (3) @(posedge sys_clk);
      check({29'h0, addrOut},
            {29'h0, ledExp()});
      check({33'h0, rxErrOut}, {33'h0, rxSymbolError});
    end
    // One activity pulse on a 10M link makes the bit-2 indicator blink
    linkUp <= 1;
    speed100 <= 0;
    frameActivity <= 1;
    @(posedge sys_clk);
    frameActivity <= 0;
    n = 0;
    repeat (4 * HALF) begin
      @(posedge sys_clk);
      if (addrOut[2] === addrStrap[2]) n = 1;
    end
    check(34'(n), 34'h1);
    n = 0;
    while (addrOut[2] !== !addrStrap[2] && n < 8 * HALF) begin
      @(posedge sys_clk);
      n++;
    end
    check({33'h0, addrOut[2]}, {33'h0, !addrStrap[2]});
    // Control register: test mode, indicator drive off, bad offsets
    axiWrite(scl_pkg::OFS_CTRL, 32'h1, scl_pkg::RESP_OKAY);
    repeat (2) @(posedge sys_clk);
    check({32'h0, ifaceOe, ifacePin === ifaceOut}, 34'h3);
    // The test signal must toggle while it is driven out
    n = 0;
    r[0] = ifaceOut;
    repeat (2 * HALF + 2) begin
      @(posedge sys_clk);
      if (ifaceOut !== r[0]) n = 1;
    end
    check(34'(n), 34'h1);
    axiRead(scl_pkg::OFS_CTRL, {scl_pkg::RESP_OKAY, 32'h1});
    axiWrite(scl_pkg::OFS_CTRL, 32'h2, scl_pkg::RESP_OKAY);
    repeat (2) @(posedge sys_clk);
    check({28'h0, ifaceOe, addrOe}, 34'h0);
    // Leave test mode and blanking on: the chip reset below must clear them
    axiWrite(scl_pkg::OFS_CTRL, 32'h3, scl_pkg::RESP_OKAY);
    axiWrite(scl_pkg::OFS_STATUS, 32'hffff, scl_pkg::RESP_OKAY);
    axiWrite(4'h8, 32'h1, scl_pkg::RESP_SLVERR);
    axiRead(4'hc, {scl_pkg::RESP_SLVERR, 32'h0});
    // A too-short chip reset still recaptures, and is flagged
    capture(5, 1'b1);
    axiRead(scl_pkg::OFS_CTRL, {scl_pkg::RESP_OKAY, 32'h0});
    for (int i = 0; i < 8; i++) begin
      {isolatePin, repeaterSelect, linkDownPowerSavePin} <= 3'(i);
      repeat (5) @(posedge sys_clk);
      check({29'h0, macIsolate, mgmtIsolate, lowPower, repeaterMode,
             powerSaveMode},
            {29'h0, i[2], i[2], i[2], i[1], i[0]});
    end
    repeat (4) @(posedge sys_clk);
    give_verdict();
  end
endmodule
